/* tx_hdlc_regs.svh */
// Constants for the transmit HDLC byte input port: timing counts and codes.
// Assumes it is included by bare name from the port module.
`ifndef TX_HDLC_REGS_SVH
`define TX_HDLC_REGS_SVH

// Line bits per half period of the demand clock (8 bits per byte).
`define DEMAND_HALF_BITS 4
// Longest run of ones sent before a zero is stuffed.
`define STUFF_RUN        5
// Idle pattern sent between bytes when nothing is queued.
`define IDLE_FLAG        8'h7e
// Default depth of the byte queue.
`define BYTE_FIFO_DEPTH  16

`endif

/* tx_hdlc_pkg.sv */
// Types shared by the transmit HDLC byte input port.
// Assumes nothing beyond the constants header.
package tx_hdlc_pkg;

  typedef enum logic [1:0] {
    ROLE_GROUNDED,
    ROLE_PLCP_STUFF,
    ROLE_HDLC_CLOCK
  } pin_role_t;

  typedef logic [7:0] frame_byte_t;

endpackage

/* byte_stream_if.sv */
// Byte stream with valid and ready between the port logic and its queue.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // byte_stream_if

/* byte_fifo.sv */
// Synchronous FIFO with parameter width and depth, valid and ready both sides.
// Assumes a single clock; clock enable freezes all state.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Fill and drain sides
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap freely, so only power-of-two depths are served.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rd_ptr];
  assign push     = ce && wr.valid && wr.ready;
  assign pop      = ce && rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // byte_fifo

/* tx_hdlc_byte_input_port.sv */
// Transmit HDLC byte input port for one channel: demand clock, byte capture,
// byte queue and zero-stuffing serialiser toward the framer.
// Assumes the framer pulses line_bit_strobe once per line bit it takes, and
// that all inputs are synchronous to clk.
//
// Notes on behaviour
// - Pin role from ATM mode and HDLC mode.
// - ATM mode: pin is trailer stuff input.
// - HDLC mode, ATM mode off: pin drives demand clock out.
// - Send request high: capture on falling edge.
// - Each capture takes one whole byte.
// - Demand clock line rate/8, slower when stuffing.
// - Accepted bytes are zero-stuffed before framer.
`timescale 1ns/1ps
`include "tx_hdlc_regs.svh"
module tx_hdlc_byte_input_port
  import tx_hdlc_pkg::*;
#(
  parameter int FIFO_DEPTH = `BYTE_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Configuration levels
  input  wire logic       atm_uni_mode,
  input  wire logic       hdlc_mode,
  // Shared pin
  input  wire logic       trailer_stuff_ctrl_in,
  output logic            tx_frame_demand_clk,
  output logic            demand_clk_oe_n,
  // Terminal equipment data
  input  wire logic       snd_msg,
  input  wire logic [7:0] tx_frame_byte_in,
  // Toward the PLCP processor
  output logic            trailer_stuff_ctrl,
  // Toward the framer
  input  wire logic       line_bit_strobe,
  output logic            line_bit,
  output logic            line_bit_valid
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  // The queue wraps its pointers, so its depth must be a power of two.
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end
  // The half-period counter is three bits wide.
  if (`DEMAND_HALF_BITS < 1 || `DEMAND_HALF_BITS > 8) begin : g_bad_half
    $error("DEMAND_HALF_BITS must lie between 1 and 8");
  end
  // The run counter of the serialiser is three bits wide.
  if (`STUFF_RUN < 1 || `STUFF_RUN > 7) begin : g_bad_run
    $error("STUFF_RUN must lie between 1 and 7");
  end

  // ----------------------------------------------------------------------
  // Pin role
  // ----------------------------------------------------------------------
  // ATM mode wins over HDLC mode; outside both the board grounds the pin.
  pin_role_t role;
  logic      hdlc_active;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      role <= ROLE_GROUNDED;
    end else if (ce) begin
      if (atm_uni_mode) begin
        role <= ROLE_PLCP_STUFF;
      end else if (hdlc_mode) begin
        role <= ROLE_HDLC_CLOCK;
      end else begin
        role <= ROLE_GROUNDED;
      end
    end
  end

  assign hdlc_active = (role == ROLE_HDLC_CLOCK);

  // The enable follows the settled role, so the pin is never driven early.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      demand_clk_oe_n    <= 1'b1;
      trailer_stuff_ctrl <= 1'b0;
    end else if (ce) begin
      demand_clk_oe_n    <= !hdlc_active;
      trailer_stuff_ctrl <= (role == ROLE_PLCP_STUFF) && trailer_stuff_ctrl_in;
    end
  end

  // ----------------------------------------------------------------------
  // Byte queue
  // ----------------------------------------------------------------------
  byte_stream_if #(.WIDTH(8)) in_bytes ();
  byte_stream_if #(.WIDTH(8)) out_bytes ();

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .wr     (in_bytes),
    .rd     (out_bytes)
  );

  // ----------------------------------------------------------------------
  // Demand clock and capture
  // ----------------------------------------------------------------------
  logic [2:0]  half_cnt;
  frame_byte_t cap_byte;
  logic        cap_valid;
  logic        half_done;

  assign half_done     = line_bit_strobe && (half_cnt == 3'(`DEMAND_HALF_BITS - 1));
  assign in_bytes.data  = cap_byte;
  assign in_bytes.valid = cap_valid;

  // A rising edge waits for queue room, so stuffing that slows the drain
  // stretches the low phase and the clock falls below line rate / 8.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_cnt            <= '0;
      tx_frame_demand_clk <= 1'b0;
    end else if (ce) begin
      if (!hdlc_active) begin
        half_cnt            <= '0;
        tx_frame_demand_clk <= 1'b0;
      end else if (half_done) begin
        if (tx_frame_demand_clk) begin
          half_cnt            <= '0;
          tx_frame_demand_clk <= 1'b0;
        end else if (in_bytes.ready && !cap_valid) begin
          half_cnt            <= '0;
          tx_frame_demand_clk <= 1'b1;
        end
      end else if (line_bit_strobe) begin
        half_cnt <= half_cnt + 3'd1;
      end
    end
  end

  // The byte is taken in the same cycle the pin falls; the equipment moved
  // it on the previous rise.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_byte  <= '0;
      cap_valid <= 1'b0;
    end else if (ce) begin
      if (hdlc_active && half_done && tx_frame_demand_clk && snd_msg) begin
        cap_byte  <= tx_frame_byte_in;
        cap_valid <= 1'b1;
      end else if (in_bytes.ready) begin
        cap_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Zero-stuffing serialiser
  // ----------------------------------------------------------------------
  frame_byte_t shreg;
  frame_byte_t cur_byte;
  logic [2:0]  bits_left;
  logic [2:0]  ones;
  logic        cur_is_data;
  logic        is_data;
  logic        stuff_now;
  logic        at_boundary;

  assign stuff_now   = is_data && (ones == 3'(`STUFF_RUN));
  assign at_boundary = (bits_left == 3'd0);

  // At a byte boundary the next queued byte is taken, or the idle flag when
  // the queue is empty. The flag is marked as non-data, so it is never
  // stuffed and it clears the run of ones.
  always_comb begin
    cur_byte    = shreg;
    cur_is_data = is_data;
    if (at_boundary) begin
      cur_byte    = out_bytes.valid ? out_bytes.data : `IDLE_FLAG;
      cur_is_data = out_bytes.valid;
    end
  end

  // A stuffed zero holds off the queue, so the byte waits for the next strobe.
  assign out_bytes.ready = hdlc_active && line_bit_strobe && !stuff_now && at_boundary;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shreg          <= '0;
      bits_left      <= '0;
      ones           <= '0;
      is_data        <= 1'b0;
      line_bit       <= 1'b0;
      line_bit_valid <= 1'b0;
    end else if (ce) begin
      line_bit_valid <= hdlc_active && line_bit_strobe;
      if (!hdlc_active) begin
        bits_left <= '0;
        ones      <= '0;
        is_data   <= 1'b0;
      end else if (line_bit_strobe) begin
        if (stuff_now) begin
          line_bit <= 1'b0;
          ones     <= '0;
        end else begin
          line_bit  <= cur_byte[0];
          shreg     <= cur_byte >> 1;
          bits_left <= at_boundary ? 3'd7 : bits_left - 3'd1;
          is_data   <= cur_is_data;
          ones      <= (cur_is_data && cur_byte[0]) ? ones + 3'd1 : 3'd0;
        end
      end
    end
  end

endmodule // tx_hdlc_byte_input_port

/* tx_hdlc_byte_input_port_props.sv */
// Checker for the transmit HDLC byte input port, on its top ports only.
// Assumes ce is held high by the bench.
`timescale 1ns/1ps
module tx_hdlc_byte_input_port_props (
  // Watched ports
  input wire logic clk,
  input wire logic resetn,
  input wire logic atm_uni_mode,
  input wire logic hdlc_mode,
  input wire logic trailer_stuff_ctrl_in,
  input wire logic tx_frame_demand_clk,
  input wire logic demand_clk_oe_n,
  input wire logic trailer_stuff_ctrl,
  input wire logic line_bit_strobe,
  input wire logic line_bit_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // Strobes seen while the demand clock is high.
  // ----
  logic [2:0] hi;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi <= '0;
    else hi <= tx_frame_demand_clk ? hi + 3'(line_bit_strobe) : '0;
  end
  // ----
  // Strobes seen while the demand clock is low, held once four are reached.
  // ----
  logic [2:0] lo;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lo <= '0;
    else if (tx_frame_demand_clk) lo <= '0;
    else if (line_bit_strobe && lo != 3'h4) lo <= lo + 3'h1;
  end
  sequence s_hdlc; (hdlc_mode && !atm_uni_mode)[*3]; endsequence
  sequence s_off; (!hdlc_mode || atm_uni_mode)[*3]; endsequence
  property p_oe_on; s_hdlc |=> !demand_clk_oe_n; endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  property p_oe_off; s_off |=> demand_clk_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_clk_off; s_off |=> !tx_frame_demand_clk && !line_bit_valid; endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock outside role");
  property p_tog; s_hdlc ##0 $changed(tx_frame_demand_clk) |-> $past(line_bit_strobe); endproperty
  a_tog: assert property (p_tog) else $error("clock moved without strobe");
  property p_fall4; s_hdlc ##0 $fell(tx_frame_demand_clk) |-> hi == 3'h4; endproperty
  a_fall4: assert property (p_fall4) else $error("high phase length");
  property p_low4; s_hdlc ##0 $rose(tx_frame_demand_clk) |-> lo == 3'h4; endproperty
  a_low4: assert property (p_low4) else $error("low phase too short");
  property p_val_on; s_hdlc ##0 line_bit_strobe |=> line_bit_valid; endproperty
  a_val_on: assert property (p_val_on) else $error("no bit after strobe");
  property p_val_src; line_bit_valid |-> $past(line_bit_strobe); endproperty
  a_val_src: assert property (p_val_src) else $error("bit without strobe");
  property p_stc_on; (atm_uni_mode && trailer_stuff_ctrl_in)[*3] |=> trailer_stuff_ctrl; endproperty
  a_stc_on: assert property (p_stc_on) else $error("stuff control lost");
endmodule // tx_hdlc_byte_input_port_props

/* equip_model.sv */
// Terminal equipment model: offers one byte per demand clock period.
// Assumes the demand clock is a registered output sampled on clk.
`timescale 1ns/1ps
module equip_model
  import tx_hdlc_pkg::*;
(
  // Clock and demand clock from the port
  input  wire logic  clk,
  input  wire logic  demand_clk,
  // Bench controls
  input  wire logic  snd_msg,
  input  wire logic  ones,
  // Byte bus toward the port
  output frame_byte_t data
);
  logic        last;
  logic        smq;
  frame_byte_t sent[$];
  initial begin
    data = '0;
    last = 0;
    smq = 0;
  end
  always @(posedge clk) begin
    if (demand_clk && !last) data <= ones ? 8'hff : frame_byte_t'($urandom);
    if (!demand_clk && last && smq) sent.push_back(data);
    last <= demand_clk;
    smq <= snd_msg;
  end
endmodule // equip_model

/* tx_hdlc_byte_input_port_test.sv */
// Testbench for the transmit HDLC byte input port.
// Assumes the package, FIFO, interface, checker and equipment model come first.
`timescale 1ns/1ps
bind tx_hdlc_byte_input_port tx_hdlc_byte_input_port_props tx_hdlc_byte_input_port_props_i (
  .clk(clk), .resetn(resetn), .atm_uni_mode(atm_uni_mode), .hdlc_mode(hdlc_mode),
  .trailer_stuff_ctrl_in(trailer_stuff_ctrl_in), .tx_frame_demand_clk(tx_frame_demand_clk),
  .demand_clk_oe_n(demand_clk_oe_n), .trailer_stuff_ctrl(trailer_stuff_ctrl),
  .line_bit_strobe(line_bit_strobe), .line_bit_valid(line_bit_valid));
module tx_hdlc_byte_input_port_test;
  logic       clk, resetn, atm, hdlc, pin, snd, strb, ones, run, dclk, oe_n, stc, lbit, lval, sync;
  logic [7:0] dat, raw, acc;
  int         bad_count, total_checks, n1, nb, got, i;
  tx_hdlc_byte_input_port tx_hdlc_byte_input_port_i (.clk(clk), .resetn(resetn), .ce(1'b1),
    .atm_uni_mode(atm), .hdlc_mode(hdlc), .trailer_stuff_ctrl_in(pin), .tx_frame_demand_clk(dclk),
    .demand_clk_oe_n(oe_n), .snd_msg(snd), .tx_frame_byte_in(dat), .trailer_stuff_ctrl(stc),
    .line_bit_strobe(strb), .line_bit(lbit), .line_bit_valid(lval));
  equip_model equip_model_i (.clk(clk), .demand_clk(dclk), .snd_msg(snd), .ones(ones), .data(dat));
  always #5 clk = ~clk;
  always @(posedge clk) strb <= run && !strb && ($urandom % 3 != 0);
  // ----
  // Receiver: finds flags, removes stuffed zeros, rebuilds bytes.
  // ----
  always @(posedge clk) begin
    if (lval) begin
      raw = {lbit, raw[7:1]};
      if (raw == 8'h7e) begin
        sync = 1;
        nb = 0;
        n1 = 0;
      end else if (n1 == 5 && !lbit) n1 = 0;
      else begin
        n1 = lbit ? n1 + 1 : 0;
        acc = {lbit, acc[7:1]};
        nb++;
        if (nb == 8 && sync) begin
          got++;
          check("byte", equip_model_i.sent.pop_front(), acc);
        end
        if (nb == 8) nb = 0;
      end
    end
  end
  task check(string what, logic [7:0] exp, logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task flags(logic e, string t);
    repeat (4) @(posedge clk);
    #1 check(t, {5'h0, e, 1'b0, atm & pin}, {5'h0, oe_n, dclk, stc});
    @(posedge clk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {clk, resetn, hdlc, pin, snd, strb, ones, run, sync, raw, acc} = '0;
    atm = 1;
    {bad_count, total_checks, n1, nb, got} = '0;
    void'($urandom(32'h1588));
    repeat (12) @(posedge clk);
    resetn <= 1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk) pin <= 1'($urandom);
      flags(1, "atm pins");
    end
    $display("test atm role done");
    atm <= 0;
    pin <= 0;
    flags(1, "ground pins");
    $display("test grounded role done");
    hdlc <= 1;
    snd <= 1;
    run <= 1;
    repeat (2500) @(posedge clk) ones <= ($urandom % 4 == 0);
    repeat (400) @(posedge clk) ones <= 1;
    #1 check("oe", 0, {7'h0, oe_n});
    @(posedge clk);
    snd <= 0;
    ones <= 0;
    repeat (2000) @(posedge clk);
    check("left", 0, 8'(equip_model_i.sent.size()));
    check("moved", 1, {7'h0, got > 50});
    $display("test hdlc stream done");
    results();
  end
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule // tx_hdlc_byte_input_port_test
